// ==== pli_led_top.sv ====
// Purpose: Per-port LED indicator logic with strap-selected LED modes.
// Assumes: Port status comes from logic on CLK_I; the strap is a board pin.
// Notes:   LEDs are active low; every top output is driven from a flop.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module pli_led_top #(
    parameter int NPORT       = pli_pkg::NUM_PORTS,
    parameter int TICK_CYCLES = pli_pkg::TICK_CYCLES
) (
    input  wire logic                   CLK_I,
    input  wire logic                   RST_I,
    input  wire logic [3:0]             LED_MODE_STRAP_I,
    input  wire pli_pkg::pli_port_stat_t PORT_STAT_I [NPORT],
    input  wire pli_pkg::pli_apb_req_t  APB_REQ_I,
    output pli_pkg::pli_apb_rsp_t       APB_RSP_O,
    output pli_pkg::pli_led_t           LED_N_O [NPORT]
);
    import pli_pkg::*;

    logic [3:0]       strap_filt;   // Strap after the synchroniser.
    logic [3:0]       strap_code;   // Strap captured once after reset.
    logic             strap_valid;  // Capture has been made.
    logic [2:0]       settle_cnt;   // Cycles since reset release.
    pli_mode_t        mode;         // Mode decoded from the captured strap.
    logic [31:0]      tick_div;     // Divider towards the base tick.
    logic             tick;         // One-cycle base tick enable.
    logic [7:0]       slow_cnt;     // Half-period counter, slow blink.
    logic [7:0]       fast_cnt;     // Half-period counter, fast blink.
    logic             slow_blink;   // Slow square wave.
    logic             fast_blink;   // Fast square wave.
    logic [1:0]       ctrl;         // Control register.
    logic [NPORT-1:0] link_vec;     // Link bits gathered for software.
    logic             apb_setup;    // Setup phase of an APB transfer.
    logic             apb_write;    // Completing write in the access phase.

    // Strap pin crosses in through three flops with agreement.
    pli_sync #(
        .WIDTH (4)
    ) u_strap_sync (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .async_i (LED_MODE_STRAP_I),
        .value_o (strap_filt)
    );

    // A strap that moves after the capture has no effect until the next reset.
    // Wait for the synchroniser to fill, then take the strap once.
    // The pin is not read under reset, so only constants load there.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            settle_cnt  <= 3'h0;
            strap_code  <= 4'h0;
            strap_valid <= 1'b0;
        end
        else if (!strap_valid)
        begin
            if (settle_cnt == 3'(STRAP_SETTLE_CYC))
            begin
                strap_code  <= strap_filt;
                strap_valid <= 1'b1;
            end
            else
                settle_cnt <= settle_cnt + 3'h1;
        end
    end

    // Decode the captured strap; codes from 0100 up are factory test.
    always_comb
    begin
        case (strap_code)
            STRAP_MODE0: mode = MODE_0;
            STRAP_MODE1: mode = MODE_1;
            STRAP_MODE2: mode = MODE_2;
            STRAP_MODE3: mode = MODE_3;
            default:     mode = MODE_FACTORY;
        endcase
    end

    // Base tick divider; one enable pulse every TICK_CYCLES clocks.
    // A wide counter lets the tick reach a millisecond at any sensible clock rate.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            tick_div <= 32'h0;
            tick     <= 1'b0;
        end
        else if (tick_div == 32'(TICK_CYCLES - 1))
        begin
            tick_div <= 32'h0;
            tick     <= 1'b1;
        end
        else
        begin
            tick_div <= tick_div + 32'h1;
            tick     <= 1'b0;
        end
    end

    // Slow blink square wave shared by all ports.
    // Both waves run free, so ports that blink together stay in step.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            slow_cnt   <= 8'h00;
            slow_blink <= 1'b0;
        end
        else if (tick)
        begin
            if (slow_cnt == 8'(SLOW_TICKS - 1))
            begin
                slow_cnt   <= 8'h00;
                slow_blink <= !slow_blink;
            end
            else
                slow_cnt <= slow_cnt + 8'h01;
        end
    end

    // Fast blink square wave shared by all ports.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            fast_cnt   <= 8'h00;
            fast_blink <= 1'b0;
        end
        else if (tick)
        begin
            if (fast_cnt == 8'(FAST_TICKS - 1))
            begin
                fast_cnt   <= 8'h00;
                fast_blink <= !fast_blink;
            end
            else
                fast_cnt <= fast_cnt + 8'h01;
        end
    end

    // Per-port stretchers and LED decode.
    // Each event has its own stretcher; sharing one would let receive
    // traffic keep the transmit indication lit.
    genvar p;
    generate
        for (p = 0; p < NPORT; p++)
        begin : g_port
            pli_port_stat_t st;      // This port's status.
            logic           act_s;   // Stretched transmit or receive.
            logic           tx_s;    // Stretched transmit.
            logic           rx_s;    // Stretched receive.
            logic           col_s;   // Stretched collision.
            logic           lnk_act; // Link solid, blinking on traffic.
            pli_led_t       next_on; // LEDs to light, active high.

            assign st          = PORT_STAT_I[p];
            assign link_vec[p] = st.link;

            pli_stretch #(.LEN (STRETCH_TICKS)) u_act (
                .clk_i    (CLK_I),
                .rst_i    (RST_I),
                .tick_i   (tick),
                .event_i  (st.tx || st.rx),
                .active_o (act_s)
            );
            pli_stretch #(.LEN (STRETCH_TICKS)) u_tx (
                .clk_i    (CLK_I),
                .rst_i    (RST_I),
                .tick_i   (tick),
                .event_i  (st.tx),
                .active_o (tx_s)
            );
            pli_stretch #(.LEN (STRETCH_TICKS)) u_rx (
                .clk_i    (CLK_I),
                .rst_i    (RST_I),
                .tick_i   (tick),
                .event_i  (st.rx),
                .active_o (rx_s)
            );
            pli_stretch #(.LEN (STRETCH_TICKS)) u_col (
                .clk_i    (CLK_I),
                .rst_i    (RST_I),
                .tick_i   (tick),
                .event_i  (st.col),
                .active_o (col_s)
            );

            // Solid with link, off without, blinking while traffic flows.
            assign lnk_act = st.link && (act_s ? fast_blink : 1'b1);

            // Choose what each LED means in the selected mode.
            always_comb
            begin
                next_on = 4'h0;
                case (mode)
                    MODE_0:
                    begin
                        next_on[0] = st.link && st.speed100;
                        next_on[1] = st.link && st.full_dup;
                        next_on[2] = col_s;
                        next_on[3] = lnk_act;
                    end
                    MODE_1:
                    begin
                        // Speed shown by blink rate while traffic flows.
                        next_on[0] = st.link && (!act_s ? 1'b1 :
                                     (st.speed100 ? fast_blink : slow_blink));
                        next_on[1] = st.link && st.full_dup;
                        next_on[2] = tx_s;
                        next_on[3] = rx_s;
                    end
                    MODE_2:
                    begin
                        next_on[0] = col_s;
                        next_on[1] = st.link && st.full_dup;
                        next_on[2] = st.link && !st.speed100 &&
                                     (act_s ? slow_blink : 1'b1);
                        next_on[3] = st.link && st.speed100 &&
                                     (act_s ? fast_blink : 1'b1);
                    end
                    MODE_3:
                    begin
                        next_on[0] = st.link && st.speed100;
                        next_on[1] = 1'b0;
                        // Full duplex holds it on; collisions flash it.
                        next_on[2] = (st.link && st.full_dup) ||
                                     (col_s && fast_blink);
                        next_on[3] = lnk_act;
                    end
                    default:
                        next_on = 4'h0; // Factory codes leave the LEDs dark.
                endcase
            end

            // Registered active-low drive; dark until the strap is taken.
            // The lamp test lights everything, useful for board bring-up.
            always_ff @(posedge CLK_I)
            begin
                if (RST_I)
                    LED_N_O[p] <= 4'hF;
                else if (ctrl[CTRL_LAMP_BIT])
                    LED_N_O[p] <= 4'h0;
                else if (!strap_valid || !ctrl[CTRL_ENABLE_BIT])
                    LED_N_O[p] <= 4'hF;
                else
                    LED_N_O[p] <= ~next_on;
            end
        end
    endgenerate

    // APB phase decode.
    assign apb_setup = APB_REQ_I.psel && !APB_REQ_I.penable;
    assign apb_write = APB_REQ_I.psel && APB_REQ_I.penable && APB_RSP_O.pready &&
                       APB_REQ_I.pwrite;

    // Control register; written only at the completing access edge.
    // Writes to the status and link words are dropped without an error.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            ctrl <= CTRL_RESET;
        else if (apb_write && APB_REQ_I.paddr == REG_CTRL)
            ctrl <= APB_REQ_I.pwdata[1:0];
    end

    // Answer prepared in the setup cycle so it leaves straight from flops.
    // This costs no wait state: pready is high during the first access cycle.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            APB_RSP_O <= '0;
        end
        else if (apb_setup)
        begin
            APB_RSP_O.pready  <= 1'b1;
            APB_RSP_O.pslverr <= 1'b0;
            APB_RSP_O.prdata  <= 32'h0;
            case (APB_REQ_I.paddr)
                REG_CTRL:
                    APB_RSP_O.prdata[1:0] <= ctrl;
                REG_STATUS:
                begin
                    APB_RSP_O.prdata[STAT_STRAP_LSB +: 4] <= strap_code;
                    APB_RSP_O.prdata[STAT_VALID_BIT]      <= strap_valid;
                    APB_RSP_O.prdata[STAT_FACTORY_BIT]    <= (mode == MODE_FACTORY);
                end
                REG_LINK:
                    APB_RSP_O.prdata[NPORT-1:0] <= link_vec;
                default:
                    APB_RSP_O.pslverr <= 1'b1; // Unmapped address.
            endcase
        end
        else
        begin
            APB_RSP_O.pready  <= 1'b0;
            APB_RSP_O.pslverr <= 1'b0;
        end
    end
endmodule

// ==== pli_pkg.sv ====
// Purpose: Shared constants and types for the port LED indicator block.
// Assumes: One 50 MHz clock, nine switch ports, four active-low LEDs per port.
// Notes:   Times are kept in their own units; cycle counts derive from them.
// Contract
// - Mode 0, third LED shows collision.
// - Mode 1, third LED lit while transmitting.
// - Mode 2, third LED shows 10 Mb/s link/activity.
// - Mode 3, third LED duplex, collision flashes.
// - Mode 0, fourth LED link solid, traffic blinks.
// - Mode 1, fourth LED lit while receiving.
// - Mode 2, fourth LED shows 100 Mb/s link/activity.
// - Mode 3, fourth LED same as mode 0.
// - Strap sampled at reset selects LED mode; the code takes it once, on the fifth clock edge after reset release.
// - Modes 0 and 3, first LED shows speed.
// - Mode 1 first LED speed blink; mode 2 collision.
// - Modes 0-2 second LED duplex; mode 3 reserved.
package pli_pkg;

    // Number of switch ports served by the block.
    localparam int NUM_PORTS = 9;

    // Clock period and the base tick period, in nanoseconds.
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS       = 1000000;
    // Cycles per base tick; above 4096, so the top exposes it as a parameter.
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // Visible times in milliseconds, converted into counts of base ticks.
    localparam int STRETCH_MS    = 60;
    localparam int SLOW_HALF_MS  = 100;
    localparam int FAST_HALF_MS  = 40;
    localparam int STRETCH_TICKS = (STRETCH_MS * 1000000) / TICK_NS;
    localparam int SLOW_TICKS    = (SLOW_HALF_MS * 1000000) / TICK_NS;
    localparam int FAST_TICKS    = (FAST_HALF_MS * 1000000) / TICK_NS;

    // Cycles after reset release before the filtered strap is trusted.
    localparam int STRAP_SETTLE_CYC = 4;

    // Strap codes of the four operating LED modes.
    localparam logic [3:0] STRAP_MODE0 = 4'h0;
    localparam logic [3:0] STRAP_MODE1 = 4'h1;
    localparam logic [3:0] STRAP_MODE2 = 4'h2;
    localparam logic [3:0] STRAP_MODE3 = 4'h3;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LINK   = 8'h08;

    // Control register field positions and reset value.
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          CTRL_LAMP_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h1;

    // Status register field positions.
    localparam int STAT_STRAP_LSB  = 0;
    localparam int STAT_VALID_BIT  = 4;
    localparam int STAT_FACTORY_BIT = 5;

    // Decoded LED mode.
    typedef enum logic [2:0] {
        MODE_0,
        MODE_1,
        MODE_2,
        MODE_3,
        MODE_FACTORY
    } pli_mode_t;

    // Status of one port as supplied by the PHY and MAC logic.
    typedef struct packed {
        logic link;      // Link is up.
        logic speed100;  // Port runs at 100 Mb/s.
        logic full_dup;  // Port runs full duplex.
        logic col;       // Collision present.
        logic tx;        // Port is transmitting.
        logic rx;        // Port is receiving.
    } pli_port_stat_t;

    // Four active-low LED drives of one port, index 0 is the first LED.
    typedef logic [3:0] pli_led_t;

    // APB request from the master.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pli_apb_req_t;

    // APB answer from the slave.
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pli_apb_rsp_t;

endpackage

// ==== pli_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to CLK_I.
// Notes:   The filtered value moves only when stages two and three agree.
`timescale 1ns/100ps
module pli_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] value_o
);
    import pli_pkg::*;

    logic [WIDTH-1:0] meta;   // First stage, read only by the second.
    logic [WIDTH-1:0] stage2; // Second stage.
    logic [WIDTH-1:0] stage3; // Third stage.

    // Shift chain; the first flop may go metastable, so nothing else reads it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta   <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            meta   <= async_i;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // Accept a change only once two settled stages show the same value.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            value_o <= '0;
        else if (stage2 == stage3)
            value_o <= stage3;
    end
endmodule

// ==== pli_stretch.sv ====
// Purpose: Pulse stretcher so short events stay visible on an LED.
// Assumes: tick_i is a one-cycle enable from a slow divider.
// Notes:   Output is high during the event and for LEN ticks after it.
`timescale 1ns/100ps
module pli_stretch #(
    parameter int LEN = 60
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tick_i,
    input  wire logic event_i,
    output logic      active_o
);
    import pli_pkg::*;

    logic [7:0] remain; // Ticks of stretch still to run.

    // Reload on every event, count down on ticks; the reload wins over the count.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            remain <= 8'h00;
        else if (event_i)
            remain <= 8'(LEN);
        else if (tick_i && remain != 8'h00)
            remain <= remain - 8'h01;
    end

    // Live event or remaining stretch keeps the indication on.
    assign active_o = event_i || (remain != 8'h00);
endmodule

// ==== pli_led_assertions.sv ====
// Purpose: Concurrent checks on the LED outputs and the APB answer of port 0.
// Assumes: The strap stays constant from reset entry until long after release.
// Notes:   The mode is tracked here; LED checks pause during lamp test, and all but a_dark also during any bus transfer.
`timescale 1ns/100ps
module pli_led_assertions #(
    parameter int NPORT       = 9,
    parameter int TICK_CYCLES = 4
) (
    input  wire logic                    CLK_I,
    input  wire logic                    RST_I,
    input  wire logic [3:0]              LED_MODE_STRAP_I,
    input  wire pli_pkg::pli_port_stat_t PORT_STAT_I [NPORT],
    input  wire pli_pkg::pli_apb_req_t   APB_REQ_I,
    input  wire pli_pkg::pli_apb_rsp_t   APB_RSP_O,
    input  wire pli_pkg::pli_led_t       LED_N_O [NPORT]
);
    import pli_pkg::*;
    // Quiet span: longer than the longest stretch, so no old event lingers.
    localparam int Q = 61 * TICK_CYCLES + 8;
    logic [3:0]     mode;  // Strap value seen during reset.
    logic           en;    // Shadow of the enable bit.
    logic           lamp;  // Shadow of the lamp test bit.
    int             age;   // Cycles since reset release.
    int             quiet; // Cycles since the last event on port 0.
    logic           ok;    // Normal display is expected.
    logic           calm;  // No event now and none recently.
    pli_port_stat_t s;     // Status of port 0.
    pli_led_t       l;     // LEDs of port 0.
    assign s = PORT_STAT_I[0];
    assign l = LED_N_O[0];
    assign ok = age > 8 && en && !lamp && !APB_REQ_I.psel && mode < 4'h4;
    assign calm = quiet == Q && !s.tx && !s.rx && !s.col;
    // Track strap, age and the control bits written over the bus.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            mode <= LED_MODE_STRAP_I;
            age  <= 0;
            en   <= 1'b1;
            lamp <= 1'b0;
        end
        else
        begin
            if (age < 15)
                age <= age + 1;
            if (APB_REQ_I.psel && APB_REQ_I.penable && APB_RSP_O.pready
                && APB_REQ_I.pwrite && APB_REQ_I.paddr == REG_CTRL)
            begin
                en   <= APB_REQ_I.pwdata[0];
                lamp <= APB_REQ_I.pwdata[1];
            end
        end
    end
    // Reset clears all stretchers, so the quiet count starts full.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            quiet <= Q;
        else if (s.tx || s.rx || s.col)
            quiet <= 0;
        else if (quiet < Q)
            quiet <= quiet + 1;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_ready;
        APB_REQ_I.psel && !APB_REQ_I.penable |=> APB_RSP_O.pready ##1 !APB_RSP_O.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready late or held");
    property p_unmap;
        APB_REQ_I.psel && !APB_REQ_I.penable && APB_REQ_I.paddr > 8'h08
            |=> APB_RSP_O.pslverr && APB_RSP_O.prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_dark;
        age > 8 && !lamp && mode[3:2] != 2'h0 |-> l == 4'hF;
    endproperty
    a_dark: assert property (p_dark) else $error("factory code lit an LED");
    property p_col0;
        ok && mode == 4'h0 && s.col |=> !l[2];
    endproperty
    a_col0: assert property (p_col0) else $error("collision not shown");
    property p_tx1;
        ok && mode == 4'h1 && s.tx |=> !l[2];
    endproperty
    a_tx1: assert property (p_tx1) else $error("transmit not shown");
    property p_rx1;
        ok && mode == 4'h1 && s.rx |=> !l[3];
    endproperty
    a_rx1: assert property (p_rx1) else $error("receive not shown");
    property p_dup;
        ok |=> l[1] != ($past(s.link) && $past(s.full_dup) && mode != 4'h3);
    endproperty
    a_dup: assert property (p_dup) else $error("duplex LED wrong");
    property p_spd;
        ok && (mode == 4'h0 || mode == 4'h3) |=> l[0] != ($past(s.link) && $past(s.speed100));
    endproperty
    a_spd: assert property (p_spd) else $error("speed LED wrong");
    property p_fd3;
        ok && mode == 4'h3 && s.link && s.full_dup |=> !l[2];
    endproperty
    a_fd3: assert property (p_fd3) else $error("full duplex not lit");
    property p_lnk;
        ok && calm && (mode == 4'h0 || mode == 4'h3) |=> l[3] != $past(s.link);
    endproperty
    a_lnk: assert property (p_lnk) else $error("idle link LED wrong");
    property p_m2;
        ok && calm && mode == 4'h2 |=> l[2] != ($past(s.link) && !$past(s.speed100))
            && l[3] != ($past(s.link) && $past(s.speed100));
    endproperty
    a_m2: assert property (p_m2) else $error("speed link LED wrong");
    property p_str;
        ok && mode == 4'h1 && $fell(s.tx) |=> !l[2] [*8];
    endproperty
    a_str: assert property (p_str) else $error("transmit not stretched");
endmodule
bind pli_led_top pli_led_assertions #(.NPORT(NPORT), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .LED_MODE_STRAP_I(LED_MODE_STRAP_I),
    .PORT_STAT_I(PORT_STAT_I), .APB_REQ_I(APB_REQ_I), .APB_RSP_O(APB_RSP_O),
    .LED_N_O(LED_N_O));

// ==== pli_board.sv ====
// Purpose: Board strap resistors that set the LED mode pins.
// Assumes: The fitted code changes only while the device is in reset.
// Notes:   Factory codes are fitted only when a scenario asks for them.
`timescale 1ns/100ps
module pli_board (
    input  wire logic [3:0] code_i,
    input  wire logic       factory_i,
    output logic      [3:0] strap_o
);
    // Upper bits are pulled low unless a factory fitting is requested.
    assign strap_o = {code_i[3:2] & {2{factory_i}}, code_i[1:0]};
endmodule

// ==== pli_led_top_bench.sv ====
// Purpose: Self-checking bench for the port LED indicator block.
// Assumes: A short tick of four cycles keeps the stretch time small.
// Notes:   Steady LED patterns are predicted from mode and status, traffic apart.
`timescale 1ns/100ps
module pli_led_top_bench;
    import pli_pkg::*;
    logic           clk, rst, err;
    logic [3:0]     code, strap;
    logic [31:0]    rd;
    pli_port_stat_t st [NUM_PORTS];
    pli_apb_req_t   req;
    pli_apb_rsp_t   rsp;
    pli_led_t       led [NUM_PORTS];
    int             n_errors, samples_checked;
    pli_board u_board (.code_i(code), .factory_i(1'b1), .strap_o(strap));
    pli_led_top #(.TICK_CYCLES(4)) DUT (.CLK_I(clk), .RST_I(rst), .LED_MODE_STRAP_I(strap),
        .PORT_STAT_I(st), .APB_REQ_I(req), .APB_RSP_O(rsp), .LED_N_O(led));
    // Free running 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Report, give the verdict and end the run.
    task automatic stop_test();
        $display("Compared %0d, mismatched %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One comparison of a register or LED value.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One comparison of the four LED drives of a port.
    task automatic cmp_led(input int p, input pli_led_t exp);
        cmp(32'(led[p]), 32'(exp));
    endtask
    // One APB transfer; waits for pready, releases the bus, then lets one idle edge pass.
    // Only the watchdog bounds the wait, so a slave that never answers fails the run.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
            @(posedge clk);
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask
    // Reset with a strap code fitted, then let the capture settle.
    task automatic boot(input logic [3:0] c);
        code <= c;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    // Steady LED drive of one port with no traffic, from mode and status.
    function automatic pli_led_t want(input int m, input pli_port_stat_t s);
        logic [3:0] on;
        on[0] = m == 2 ? s.col : m == 1 ? s.link : s.link & s.speed100;
        on[1] = m != 3 && s.link && s.full_dup;
        on[2] = m == 0 ? s.col : m == 1 ? s.tx : m == 2 ? s.link & !s.speed100
              : s.link & s.full_dup;
        on[3] = m == 1 ? s.rx : m == 2 ? s.link & s.speed100 : s.link;
        return m > 3 ? 4'hF : ~on;
    endfunction
    // Hang guard, far beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    // Main sequence: every strap code, then traffic, then registers.
    initial
    begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        code = 4'h0;
        req = '0;
        st = '{default: '0};
        for (int m = 0; m < 16; m++)
        begin
            boot(4'(m));
            apb(1'b0, REG_STATUS, 32'h0);
            cmp(rd, {26'h0, m > 3, 1'b1, 4'(m)});
            for (int k = 0; k < 8; k++)
            begin
                foreach (st[p]) st[p] <= {3'(k + p), 3'b000};
                repeat (3) @(posedge clk);
                foreach (led[p]) cmp_led(p, want(m, {3'(k + p), 3'b000}));
            end
        end
        // Single-cycle transmit and receive in mode 1 must stay visible.
        foreach (st[p]) st[p] <= '0;
        boot(4'h1);
        st[0] <= 6'h03;
        @(posedge clk);
        st[0] <= 6'h00;
        @(posedge clk);
        cmp_led(0, 4'h3);
        repeat (228) @(posedge clk);
        cmp_led(0, 4'h3);
        repeat (40) @(posedge clk);
        cmp_led(0, 4'hF);
        // Single-cycle collision in mode 0.
        boot(4'h0);
        st[0] <= 6'h04;
        @(posedge clk);
        st[0] <= 6'h00;
        @(posedge clk);
        cmp_led(0, 4'hB);
        repeat (270) @(posedge clk);
        cmp_led(0, 4'hF);
        // Registers: link map, reset value, refusal, lamp test, disable.
        foreach (st[p]) st[p] <= {p[0], 5'h00};
        repeat (2) @(posedge clk);
        apb(1'b0, REG_LINK, 32'h0);
        cmp(rd, 32'h000000AA);
        apb(1'b0, REG_CTRL, 32'h0);
        cmp(rd, 32'h00000001);
        apb(1'b0, 8'h0C, 32'h0);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
        // The LED flops take the new control word one edge after the write lands.
        apb(1'b1, REG_CTRL, 32'h3);
        @(posedge clk);
        cmp_led(2, 4'h0);
        apb(1'b1, REG_CTRL, 32'h0);
        @(posedge clk);
        cmp_led(1, 4'hF);
        stop_test();
    end
endmodule
